//--- tpt_pulse_shaper.sv
/*
 * Per-channel transmit pulse shaping with preset templates and a
 * user-programmable waveform RAM, reached over an APB slave.
 * Assumes one clock, a synchronous active-high reset and a symbol
 * source that presents the next line symbol when ui_strobe pulses.
 * Assumes software leaves paddr bits outside [9:2] at zero; other
 * addresses answer with an error. Waveform RAM is not reset.
 */
`timescale 1ns/1ps
module tpt_pulse_shaper
    import tpt_pkg::*;
#(
    parameter int NUM_CH = 4 // Number of line channels
)
(
    input  wire logic              core_clk,    // Core clock
    input  wire logic              sys_rst,     // Synchronous reset
    input  wire logic [11:0]       paddr,       // APB address
    input  wire logic              psel,        // APB select
    input  wire logic              penable,     // APB enable
    input  wire logic              pwrite,      // APB direction
    input  wire logic [31:0]       pwdata,      // APB write data
    output logic      [31:0]       prdata,      // APB read data
    output logic                   pready,      // APB ready
    output logic                   pslverr,     // APB error
    input  wire logic [NUM_CH-1:0] tx_mark_pos, // Positive mark next UI
    input  wire logic [NUM_CH-1:0] tx_mark_neg, // Negative mark next UI
    output logic                   ui_strobe,   // Symbol taken this cycle
    output logic [NUM_CH*7-1:0]    dac_code,    // Shaped samples, sign-magnitude
    output logic                   irq          // Overflow interrupt
);

    // Bus state
    logic              pready_ff;
    logic              pslverr_ff;
    logic [31:0]       prdata_ff;
    logic [7:0]        rd_byte;
    logic              rd_hit;
    logic              acc;
    logic              wr;
    logic [7:0]        idx;
    logic [7:0]        wbyte;
    logic              addr_ok;

    // Global and per-channel control
    logic              line_std_ff;
    logic [1:0]        chan_sel_ff;
    logic [NUM_CH-1:0] ovf_mask_ff;
    logic [NUM_CH-1:0] ovf_flag_ff;
    logic [SEL_W-1:0]  tmpl_sel_ff [NUM_CH];
    logic [GAIN_W-1:0] gain_ff     [NUM_CH];
    logic [UI_W-1:0]   ui_idx_ff   [NUM_CH];
    logic [SP_W-1:0]   sp_idx_ff   [NUM_CH];
    logic              dir_ff      [NUM_CH];
    logic              trig_ff     [NUM_CH];
    logic              romref_ff   [NUM_CH];
    logic [6:0]        sdata_ff    [NUM_CH];
    // Waveform RAM, one 64-entry array per channel
    logic [6:0]        wave_ram_ff [NUM_CH][RAM_DEPTH];

    // Playback state
    logic [SP_W-1:0]   phase_ff;
    logic              ui_strobe_ff;
    logic [1:0]        sym_ff      [NUM_CH][NUM_UI];
    logic [6:0]        dac_ff      [NUM_CH];
    logic              irq_ff;
    // Overflow events of this cycle, one per channel
    logic [NUM_CH-1:0] ovf_evt;

    // Signed-magnitude to two's complement
    // Bit 6 is the sign, so minus zero folds to zero
    function automatic logic signed [9:0] sm2s(input logic [6:0] v);
        logic signed [9:0] m;
        m = signed'({4'h0, v[5:0]});
        return v[6] ? -m : m;
    endfunction : sm2s

    // APB access decode
    // Only aligned words inside the register window are mapped
    assign addr_ok = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
    assign acc   = psel && penable && !pready_ff;
    assign wr    = acc && pwrite && addr_ok;
    assign idx   = paddr[9:2];
    assign wbyte = pwdata[7:0];

    // Read multiplexer for the selected channel
    always_comb begin
        rd_hit  = 1'b1;
        rd_byte = 8'h00;
        unique case (idx)
            IDX_TEMPLATE_CFG:  rd_byte = {4'h0, tmpl_sel_ff[chan_sel_ff]};
            IDX_AMPLITUDE_CFG: rd_byte = {2'b00, gain_ff[chan_sel_ff]};
            IDX_RAM_ACCESS:    rd_byte = {trig_ff[chan_sel_ff],
                                          dir_ff[chan_sel_ff],
                                          ui_idx_ff[chan_sel_ff],
                                          sp_idx_ff[chan_sel_ff]};
            IDX_SAMPLE_DATA:   rd_byte = {romref_ff[chan_sel_ff],
                                          sdata_ff[chan_sel_ff]};
            IDX_IRQ_MASK:      rd_byte = 8'(ovf_mask_ff);
            IDX_IRQ_STATUS:    rd_byte = 8'(ovf_flag_ff);
            IDX_CHAN_SEL:      rd_byte = {6'h00, chan_sel_ff};
            IDX_LINE_STD:      rd_byte = {7'h00, line_std_ff};
            default:           rd_hit  = 1'b0;
        endcase
        // Addresses outside the window read zero with an error
        if (!addr_ok) begin
            rd_hit  = 1'b0;
            rd_byte = 8'h00;
        end
    end

    // APB answer one cycle into the access phase
    // One wait state; upper byte lanes always read zero
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= acc;
            pslverr_ff <= acc && !rd_hit;
            if (acc && !pwrite) prdata_ff <= {24'h00_0000, rd_byte};
        end
    end

    // Global registers
    // Channel select steers every per-channel access
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            line_std_ff <= 1'b0;
            chan_sel_ff <= 2'b00;
            ovf_mask_ff <= '0;
        end else if (wr) begin
            if (idx == IDX_LINE_STD) line_std_ff <= wbyte[0];
            if (idx == IDX_CHAN_SEL) chan_sel_ff <= wbyte[1:0];
            if (idx == IDX_IRQ_MASK) ovf_mask_ff <= wbyte[NUM_CH-1:0];
        end
    end

    // Sticky overflow flags, write one to clear, set wins
    // An event in the clearing cycle keeps the flag set
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ovf_flag_ff <= '0;
        end else begin
            ovf_flag_ff <= (ovf_flag_ff
                & ~((wr && idx == IDX_IRQ_STATUS) ? wbyte[NUM_CH-1:0] : '0))
                | ovf_evt;
        end
    end

    // Interrupt output gated by the mask
    // The flag stays readable while masked; only irq is gated
    always_ff @(posedge core_clk) begin
        if (sys_rst) irq_ff <= 1'b0;
        else irq_ff <= |(ovf_flag_ff & ovf_mask_ff);
    end

    // Sub-phase counter, one UI every sixteen clocks
    // Strobe leads the wrap so a new symbol meets phase zero
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            phase_ff     <= '0;
            ui_strobe_ff <= 1'b0;
        end else begin
            phase_ff     <= phase_ff + 1'b1;
            ui_strobe_ff <= (phase_ff == 4'hE);
        end
    end

    // Per-channel register file, RAM and shaping
    // Each channel owns its registers, RAM and output path
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        logic             ch_wr;
        logic             arb;
        logic [2:0]       rom_idx;
        logic [ADDR_W-1:0] ram_addr;
        logic [6:0]       rom_rd;
        logic [6:0]       tap      [NUM_UI];
        logic signed [9:0] sum;
        logic signed [17:0] scaled;
        logic [9:0]       mag;
        logic             ovf;

        // Write strobe, playback mode and RAM address of this channel
        assign ch_wr    = wr && (chan_sel_ff == 2'(c));
        assign arb      = (tmpl_sel_ff[c][3:2] == SEL_ARB_TOP);
        assign ram_addr = {ui_idx_ff[c], sp_idx_ff[c]};

        // Preset template number from line standard and select
        // Codes below the first T1 grade fall back to grade zero
        always_comb begin
            if (!line_std_ff)
                rom_idx = tmpl_sel_ff[c][0] ? ROM_E1_120 : ROM_E1_75;
            else if (tmpl_sel_ff[c][2:0] < ROM_T1_0)
                rom_idx = ROM_T1_0;
            else
                rom_idx = tmpl_sel_ff[c][2:0];
        end

        // Reference store read for software
        // It follows the template that the select field names
        tpt_template_rom u_ref_rom (
            .rom_idx (rom_idx),
            .addr    (ram_addr),
            .sample  (rom_rd)
        );

        // Configuration registers
        // Gain resets to unity so a new RAM shape plays unscaled
        always_ff @(posedge core_clk) begin
            if (sys_rst) begin
                tmpl_sel_ff[c] <= RST_TEMPLATE;
                gain_ff[c]     <= RST_GAIN;
                ui_idx_ff[c]   <= '0;
                sp_idx_ff[c]   <= '0;
                dir_ff[c]      <= 1'b0;
            end else if (ch_wr) begin
                if (idx == IDX_TEMPLATE_CFG) tmpl_sel_ff[c] <= wbyte[3:0];
                if (idx == IDX_AMPLITUDE_CFG) gain_ff[c] <= wbyte[5:0];
                if (idx == IDX_RAM_ACCESS) begin
                    sp_idx_ff[c] <= wbyte[RAC_SP_LSB +: SP_W];
                    ui_idx_ff[c] <= wbyte[RAC_UI_LSB +: UI_W];
                    dir_ff[c]    <= wbyte[RAC_DIR_BIT];
                end
            end
        end

        // Trigger, sample data and RAM access
        // Writes landing in the one-cycle access itself are dropped
        always_ff @(posedge core_clk) begin
            if (sys_rst) begin
                trig_ff[c]   <= 1'b0;
                sdata_ff[c]  <= '0;
                romref_ff[c] <= 1'b0;
            end else if (trig_ff[c]) begin
                trig_ff[c] <= 1'b0;
                if (dir_ff[c])
                    sdata_ff[c] <= romref_ff[c] ? rom_rd
                                                : wave_ram_ff[c][ram_addr];
            end else if (ch_wr) begin
                if (idx == IDX_RAM_ACCESS) trig_ff[c] <= wbyte[RAC_TRIG_BIT];
                if (idx == IDX_SAMPLE_DATA) begin
                    sdata_ff[c]  <= wbyte[6:0];
                    romref_ff[c] <= wbyte[RSD_ROMREF_BIT];
                end
            end
        end

        // Waveform RAM write
        // No reset: contents are undefined until software fills them
        always_ff @(posedge core_clk) begin
            if (trig_ff[c] && !dir_ff[c])
                wave_ram_ff[c][ram_addr] <= sdata_ff[c];
        end

        // Symbol history, newest in slot 0
        // Both rails or neither is a space and adds nothing
        always_ff @(posedge core_clk) begin
            if (sys_rst) begin
                for (int k = 0; k < NUM_UI; k++) sym_ff[c][k] <= 2'b00;
            end else if (ui_strobe_ff) begin
                sym_ff[c][0] <= {tx_mark_neg[c], tx_mark_pos[c]};
                for (int k = 1; k < NUM_UI; k++) sym_ff[c][k] <= sym_ff[c][k-1];
            end
        end

        // Sample taps of the four overlapping pulses
        // Slot k plays interval k of the pulse sent k symbols ago
        for (genvar k = 0; k < NUM_UI; k++) begin : g_tap
            logic [6:0] rom_tap;
            tpt_template_rom u_rom (
                .rom_idx (rom_idx),
                .addr    ({2'(k), phase_ff}),
                .sample  (rom_tap)
            );
            assign tap[k] = arb ? wave_ram_ff[c][{2'(k), phase_ff}] : rom_tap;
        end

        // Overlap sum, gain and overflow
        // Gain scales the RAM shape only; presets pass unscaled
        // Four taps fit ten bits, the gain product eighteen
        always_comb begin
            sum = '0;
            for (int k = 0; k < NUM_UI; k++) begin
                if (sym_ff[c][k] == 2'b01) sum = sum + sm2s(tap[k]);
                else if (sym_ff[c][k] == 2'b10) sum = sum - sm2s(tap[k]);
            end
            if (arb)
                scaled = 18'((18'(sum) * signed'({12'h000, gain_ff[c]}))
                         / GAIN_UNITY);
            else
                scaled = 18'(sum);
            // Magnitude and overflow of the scaled sum
            mag = scaled[17] ? 10'(-scaled) : 10'(scaled);
            ovf = arb && (scaled > AMP_MAX || scaled < -AMP_MAX);
        end

        assign ovf_evt[c] = ovf;

        // Registered, clamped output sample
        // Overflow clamps to full scale with the sum's sign
        always_ff @(posedge core_clk) begin
            if (sys_rst) dac_ff[c] <= 7'h00;
            else if (ovf) dac_ff[c] <= {scaled[17], 6'h3F};
            else dac_ff[c] <= {scaled[17], mag[5:0]};
        end

        // Channel c occupies dac_code bits 7c+6 down to 7c
        assign dac_code[c*7 +: 7] = dac_ff[c];
    end

    // Output drive
    // Each output comes straight from a flip-flop
    assign prdata    = prdata_ff;
    assign pready    = pready_ff;
    assign pslverr   = pslverr_ff;
    assign ui_strobe = ui_strobe_ff;
    assign irq       = irq_ff;

endmodule : tpt_pulse_shaper

//--- tpt_pkg.sv
/*
 * Shared constants of the transmit pulse template block: register
 * indexes, field positions, reset values and waveform geometry.
 * Assumes the APB byte address of a register is four times its index.
 */
package tpt_pkg;

    // Register indexes (byte address is four times the index)
    localparam logic [7:0] IDX_TEMPLATE_CFG   = 8'h03;
    localparam logic [7:0] IDX_AMPLITUDE_CFG  = 8'h04;
    localparam logic [7:0] IDX_RAM_ACCESS     = 8'h05;
    localparam logic [7:0] IDX_SAMPLE_DATA    = 8'h06;
    localparam logic [7:0] IDX_IRQ_MASK       = 8'h12;
    localparam logic [7:0] IDX_IRQ_STATUS     = 8'h17;
    localparam logic [7:0] IDX_CHAN_SEL       = 8'h20;
    localparam logic [7:0] IDX_LINE_STD       = 8'h40;

    // Field positions in wave_ram_access_ctrl
    localparam int RAC_SP_LSB   = 0;
    localparam int RAC_UI_LSB   = 4;
    localparam int RAC_DIR_BIT  = 6;
    localparam int RAC_TRIG_BIT = 7;
    // Field positions in wave_ram_sample_data
    localparam int RSD_ROMREF_BIT = 7;

    // Waveform geometry
    localparam int UI_W     = 2;
    localparam int SP_W     = 4;
    localparam int ADDR_W   = UI_W + SP_W;
    localparam int NUM_UI   = 4;
    localparam int RAM_DEPTH = 64;
    localparam int SAMPLE_W = 7;
    localparam int SEL_W    = 4;
    localparam int GAIN_W   = 6;

    // Template encodings
    localparam logic [1:0] SEL_ARB_TOP = 2'b11;
    localparam logic [2:0] ROM_E1_75   = 3'h0;
    localparam logic [2:0] ROM_E1_120  = 3'h1;
    localparam logic [2:0] ROM_T1_0    = 3'h2;
    localparam logic [2:0] ROM_J1      = 3'h7;

    // Reset values
    localparam logic [3:0] RST_TEMPLATE = 4'h0;
    localparam logic [5:0] RST_GAIN     = 6'b100001;
    localparam int         GAIN_UNITY   = 33;
    localparam int         AMP_MAX      = 63;

    // E1 reference template shapes
    localparam logic [6:0] E1_75_EDGE  = 7'b0001100;
    localparam logic [6:0] E1_75_FLAT  = 7'b0110000;
    localparam logic [6:0] E1_120_EDGE = 7'b0001111;
    localparam logic [6:0] E1_120_FLAT = 7'b0111100;
    localparam logic [3:0] E1_EDGE_SP  = 4'h3;
    localparam logic [3:0] E1_FLAT_LO  = 4'h4;
    localparam logic [3:0] E1_FLAT_HI  = 4'hB;

endpackage : tpt_pkg

//--- tpt_template_rom.sv
/*
 * Read-only store of the standard pulse templates; only the two E1 shapes hold samples, other template numbers read zero.
 * Assumes a combinational read; the caller registers what it needs.
 */
`timescale 1ns/1ps
module tpt_template_rom
    import tpt_pkg::*;
(
    input  wire logic [2:0]        rom_idx, // Template number
    input  wire logic [ADDR_W-1:0] addr,    // Unit interval and sub-phase
    output logic      [6:0]        sample   // Signed-magnitude sample
);

    logic [UI_W-1:0] ui;
    logic [SP_W-1:0] sp;
    logic            flat;

    // Address split and flat-top window
    assign ui   = addr[ADDR_W-1:SP_W];
    assign sp   = addr[SP_W-1:0];
    assign flat = (sp >= E1_FLAT_LO) && (sp <= E1_FLAT_HI);

    // Lookup of the stored shapes
    always_comb begin
        sample = 7'h00;
        if (ui == 2'd0) begin
            unique case (rom_idx)
                ROM_E1_75: begin
                    if (sp == E1_EDGE_SP) sample = E1_75_EDGE;
                    else if (flat) sample = E1_75_FLAT;
                end
                ROM_E1_120: begin
                    if (sp == E1_EDGE_SP) sample = E1_120_EDGE;
                    else if (flat) sample = E1_120_FLAT;
                end
                default: sample = 7'h00;
            endcase
        end
    end

endmodule : tpt_template_rom

//--- tpt_pulse_shaper_checker.sv
/* Port checker for the pulse shaper: APB timing, strobe cadence,
   reset state and interrupt release.
   Assumes it is bound to the shaper top with the same NUM_CH. */
`timescale 1ns/1ps
module tpt_pulse_shaper_checker #(
    parameter int NUM_CH = 4 // Channel count
)(
    input wire logic              core_clk,    // Clock
    input wire logic              sys_rst,     // Reset
    input wire logic [11:0]       paddr,       // Address
    input wire logic              psel,        // Select
    input wire logic              penable,     // Enable
    input wire logic              pwrite,      // Direction
    input wire logic [31:0]       pwdata,      // Write data
    input wire logic [31:0]       prdata,      // Read data
    input wire logic              pready,      // Ready
    input wire logic              pslverr,     // Error
    input wire logic [NUM_CH-1:0] tx_mark_pos, // Plus marks
    input wire logic [NUM_CH-1:0] tx_mark_neg, // Minus marks
    input wire logic              ui_strobe,   // Symbol strobe
    input wire logic [NUM_CH*7-1:0] dac_code,  // Samples
    input wire logic              irq          // Interrupt
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // Bus answer timing
    a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready not one cycle after access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_slverr_ready: assert property (pslverr |-> pready && psel && penable)
        else $error("pslverr outside an answer");
    a_upper_zero: assert property (prdata[31:8] == 24'h00_0000)
        else $error("prdata upper bits not zero");
    a_read_hold: assert property (
        !$past(sys_rst) && $changed(prdata) |-> pready && !pwrite)
        else $error("prdata changed outside a read");
    // Sub-phase cadence
    a_strobe_period: assert property (ui_strobe |-> ##16 ui_strobe)
        else $error("ui_strobe not every 16 cycles");
    a_strobe_single: assert property (ui_strobe |=> !ui_strobe[*8])
        else $error("ui_strobe repeated early");
    // Quiet outputs after reset
    a_reset_quiet: assert property ($past(sys_rst) |->
        !pready && !irq && !ui_strobe && dac_code == '0)
        else $error("outputs not quiet after reset");
    // Interrupt drops only after a register write
    a_irq_release: assert property (
        !$past(sys_rst) && $fell(irq) |-> $past(psel && penable && pwrite, 2))
        else $error("irq fell without a write");
endmodule : tpt_pulse_shaper_checker

//--- tx_pulse_template_ram_test.sv
/* Self-checking bench for the pulse shaper: registers, waveform RAM,
   reference store and overflow flag over APB, with random marks.
   Assumes channel 0 is selected after reset. */
`timescale 1ns/1ps
module tx_pulse_template_ram_test;
    import tpt_pkg::*;
    localparam int NC = 4;
    logic            core_clk, sys_rst, psel, penable, pwrite;
    logic [11:0]     paddr;
    logic [31:0]     pwdata, prdata;
    logic            pready, pslverr, ui_strobe, irq, serr;
    logic [NC-1:0]   tx_mark_pos, tx_mark_neg;
    logic [NC*7-1:0] dac_code;
    logic [7:0]      rd;
    logic [15:0]     lf;
    logic [6:0]      mem [64];
    int              err_total, num_checks, cyc;

    tpt_pulse_shaper #(.NUM_CH(NC)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_mark_pos(tx_mark_pos), .tx_mark_neg(tx_mark_neg),
        .ui_strobe(ui_strobe), .dac_code(dac_code), .irq(irq));

    // Clock and hang limit
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 30000) begin
            err_total++;
            report_and_stop();
        end
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    // Reference store content by template kind (2 = T1 grade 0, 3 = J1)
    function automatic logic [6:0] rom_exp(input int k, input logic [5:0] a);
        if (k >= 2 || a[5:4] != 2'b00 || a[3:0] < 4'h3 || a[3:0] > 4'hB)
            return 7'h00;
        if (a[3:0] == 4'h3)
            return (k == 1) ? 7'b0001111 : 7'b0001100;
        return (k == 1) ? 7'b0111100 : 7'b0110000;
    endfunction : rom_exp

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // One APB transfer, then one idle edge
    task automatic apb(input logic w, input logic [7:0] ix, input logic [7:0] wd);
        paddr  <= {2'b00, ix, 2'b00};
        pwrite <= w;
        pwdata <= {24'h00_0000, wd};
        psel   <= 1'b1;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata[7:0];
        serr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb

    // Trigger a RAM access and check the trigger clears
    task automatic ram_op(input logic [5:0] a, input logic dir);
        apb(1'b1, IDX_RAM_ACCESS, {1'b1, dir, a});
        repeat (2) @(posedge core_clk);
        apb(1'b0, IDX_RAM_ACCESS, 8'h00);
        chk("trigger", {1'b0, dir, a}, rd);
    endtask : ram_op

    // Program one sample: address, value, then direction and trigger
    task automatic ram_wr(input logic [5:0] a, input logic [7:0] d);
        apb(1'b1, IDX_RAM_ACCESS, {2'b00, a});
        apb(1'b1, IDX_SAMPLE_DATA, d);
        ram_op(a, 1'b0);
    endtask : ram_wr

    // Random marks on channel 0
    task automatic marks(input int n);
        repeat (n) begin
            @(posedge core_clk);
            lf = lfsr_next(lf);
            tx_mark_pos <= {3'b000, lf[0]};
            tx_mark_neg <= {3'b000, lf[1]};
        end
        @(posedge core_clk);
        tx_mark_pos <= '0;
        tx_mark_neg <= '0;
        repeat (80) @(posedge core_clk);
    endtask : marks

    // One isolated mark on channel 0, looked at mid-interval and after it
    task automatic pulse(input logic neg, input logic [7:0] g, input logic [6:0] e);
        apb(1'b1, IDX_AMPLITUDE_CFG, g);
        tx_mark_pos <= {3'b000, !neg};
        tx_mark_neg <= {3'b000, neg};
        do @(posedge core_clk); while (ui_strobe !== 1'b1);
        tx_mark_pos <= '0;
        tx_mark_neg <= '0;
        repeat (8) @(posedge core_clk);
        chk("dac ch0", {1'b0, e}, {1'b0, dac_code[6:0]});
        chk("dac ch1", 8'h00, {1'b0, dac_code[13:7]});
        repeat (80) @(posedge core_clk);
        chk("dac idle", 8'h00, {1'b0, dac_code[6:0]});
    endtask : pulse

    task automatic report_and_stop;
        $display("Checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop

    initial begin
        {core_clk, psel, penable, pwrite, paddr, pwdata} = '0;
        {tx_mark_pos, tx_mark_neg, err_total, num_checks, cyc} = '0;
        sys_rst = 1'b1;
        lf = 16'd10598;
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        // Reset values, read/write, unmapped place
        apb(1'b0, IDX_AMPLITUDE_CFG, 8'h00);
        chk("gain reset", 8'h21, rd);
        apb(1'b0, 8'h3F, 8'h00);
        chk("unmapped", 8'h01, {7'h00, serr});
        apb(1'b1, IDX_TEMPLATE_CFG, 8'h0C);
        apb(1'b0, IDX_TEMPLATE_CFG, 8'h00);
        chk("template", 8'h0C, rd);
        chk("mapped", 8'h00, {7'h00, serr});
        // Channel select keeps per-channel registers apart
        apb(1'b1, IDX_CHAN_SEL, 8'h01);
        apb(1'b1, IDX_TEMPLATE_CFG, 8'h05);
        apb(1'b0, IDX_TEMPLATE_CFG, 8'h00);
        chk("template ch1", 8'h05, rd);
        apb(1'b0, IDX_CHAN_SEL, 8'h00);
        chk("channel select", 8'h01, rd);
        apb(1'b1, IDX_CHAN_SEL, 8'h00);
        apb(1'b0, IDX_TEMPLATE_CFG, 8'h00);
        chk("template ch0", 8'h0C, rd);
        // Random fill of RAM words 0 to 62, 7F in word 63, then read back
        for (int a = 0; a < 64; a++) begin
            lf = lfsr_next(lf);
            mem[a] = (a == 63) ? 7'h7F : lf[6:0];
            ram_wr(a[5:0], {1'b0, mem[a]});
        end
        for (int a = 0; a < 64; a++) begin
            ram_op(a[5:0], 1'b1);
            apb(1'b0, IDX_SAMPLE_DATA, 8'h00);
            chk("ram word", {1'b0, mem[a]}, {1'b0, rd[6:0]});
        end
        // Reference store: E1 75, E1 120, T1 grade 0, J1
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, IDX_LINE_STD, {7'h00, k >= 2});
            apb(1'b1, IDX_TEMPLATE_CFG,
                (k == 3) ? 8'h07 : {7'h00, k == 1});
            apb(1'b1, IDX_SAMPLE_DATA, 8'h80);
            for (int a = 0; a < 64; a++) begin
                ram_op(a[5:0], 1'b1);
                apb(1'b0, IDX_SAMPLE_DATA, 8'h00);
                chk("ref word", {1'b0, rom_exp(k, a[5:0])}, {1'b0, rd[6:0]});
            end
        end
        // Shape at full scale in the first interval only
        apb(1'b1, IDX_LINE_STD, 8'h00);
        for (int a = 0; a < 64; a++)
            ram_wr(a[5:0], (a < 16) ? 8'h3F : 8'h00);
        apb(1'b1, IDX_AMPLITUDE_CFG, 8'h3F);
        apb(1'b1, IDX_TEMPLATE_CFG, 8'h00);
        marks(160);
        apb(1'b0, IDX_IRQ_STATUS, 8'h00);
        chk("preset overflow", 8'h00, rd);
        apb(1'b1, IDX_TEMPLATE_CFG, 8'h0C);
        marks(160);
        apb(1'b0, IDX_IRQ_STATUS, 8'h00);
        chk("overflow flag", 8'h01, rd);
        chk("masked irq", 8'h00, {7'h00, irq});
        apb(1'b1, IDX_IRQ_MASK, 8'h01);
        @(posedge core_clk);
        chk("irq", 8'h01, {7'h00, irq});
        apb(1'b0, IDX_IRQ_STATUS, 8'h00);
        chk("flag held", 8'h01, rd);
        apb(1'b1, IDX_IRQ_STATUS, 8'h01);
        apb(1'b0, IDX_IRQ_STATUS, 8'h00);
        chk("flag clear", 8'h00, rd);
        chk("irq clear", 8'h00, {7'h00, irq});
        // Unity gain gives +63; gain 27 on -63 gives -51
        pulse(1'b0, 8'h21, 7'h3F);
        pulse(1'b1, 8'h1B, 7'h73);
        apb(1'b0, IDX_IRQ_STATUS, 8'h00);
        chk("no overflow", 8'h00, rd);
        report_and_stop();
    end
endmodule : tx_pulse_template_ram_test

bind tpt_pulse_shaper tpt_pulse_shaper_checker #(.NUM_CH(NUM_CH)) u_chk (
    .core_clk(core_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_mark_pos(tx_mark_pos),
    .tx_mark_neg(tx_mark_neg), .ui_strobe(ui_strobe), .dac_code(dac_code),
    .irq(irq));
